// >>> common/ahrm_pkg.sv
// Purpose: Shared constants and carriers for the analyzer holding-register bank.
// Assumes: 16-bit register words addressed by register number.
// Notes: Wide values occupy an even/odd register pair, high word at the even number.
package ahrm_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned WORD_W = 16;

  // Register numbers
  localparam logic [15:0] REG_H2_HI = 16'h0000;
  localparam logic [15:0] REG_H2_LO = 16'h0001;
  localparam logic [15:0] REG_MODEL_BASE = 16'h001F;
  localparam logic [15:0] REG_PSER_BASE = 16'h0029;
  localparam logic [15:0] REG_SSER_BASE = 16'h0033;
  localparam logic [15:0] REG_FW_BASE = 16'h0059;
  localparam logic [15:0] REG_STRING_LEN = 16'h000A;
  localparam logic [15:0] REG_UNIT_STATUS = 16'h006F;
  localparam logic [15:0] REG_ERR_HI = 16'h0070;
  localparam logic [15:0] REG_GAS1_HI = 16'h007E;
  localparam logic [15:0] REG_DATE_HI = 16'h0080;
  localparam logic [15:0] REG_GAS2_HI = 16'h0082;
  localparam logic [15:0] REG_CAL_BEGIN = 16'h0084;
  localparam logic [15:0] REG_CAL_CANCEL = 16'h0085;
  localparam logic [15:0] REG_CAL_PROGRESS = 16'h0086;
  localparam logic [15:0] REG_GAS_SELECT = 16'h0087;

  // Field positions and value ranges
  localparam int unsigned READY_BIT = 15;
  localparam logic [15:0] CAL_MIN_MINUTES = 16'h003C;
  localparam logic [15:0] CAL_MAX_MINUTES = 16'h05A0;
  localparam logic [31:0] GAS_MAX_PPM = 32'h000F_4240;
  localparam logic [15:0] CMD_ABORT = 16'h0001;
  localparam logic [15:0] CMD_CLEAR = 16'h0002;
  localparam logic [15:0] CMD_GAS_ONE = 16'h0001;
  localparam logic [15:0] CMD_GAS_TWO = 16'h0002;

  // Reset values
  localparam logic [31:0] WIDE_RESET = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ahrm_req_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [15:0] rdata;
  } ahrm_rsp_t;

  typedef struct packed {
    logic start;
    logic [15:0] minutes;
    logic abort;
    logic clear;
    logic gas_one;
    logic gas_two;
  } ahrm_cal_cmd_t;

  // True when addr falls in [base, base+count)
  function automatic logic ahrm_in_span(input logic [15:0] addr, input logic [15:0] base,
                                        input logic [15:0] count);
    logic [16:0] top;
    top = {1'b0, base} + {1'b0, count};
    return ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < top);
  endfunction

endpackage

// >>> verilog/ahrm_string_rom.sv
// Purpose: Read-only ASCII identification strings, ten registers each.
// Assumes: First register of a string holds its first two characters.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module ahrm_string_rom import ahrm_pkg::*; #(
  parameter logic [159:0] MODEL_STR = {"MODEL-A", {13{8'h20}}},
  parameter logic [159:0] PSER_STR = {"PSN-0000", {12{8'h20}}},
  parameter logic [159:0] SSER_STR = {"SSN-0000", {12{8'h20}}},
  parameter logic [159:0] FW_STR = {"FW-0.0", {14{8'h20}}}
) (
  input wire logic [15:0] addr,
  output logic hit,
  output logic [15:0] word
);

  logic [159:0] sel_str;
  logic [15:0] offs;
  logic [3:0] idx;

  always_comb begin
    sel_str = '0;
    offs = '0;
    hit = 1'b0;
    if (ahrm_in_span(addr, REG_MODEL_BASE, REG_STRING_LEN)) begin
      sel_str = MODEL_STR;
      offs = addr - REG_MODEL_BASE;
      hit = 1'b1;
    end else if (ahrm_in_span(addr, REG_PSER_BASE, REG_STRING_LEN)) begin
      sel_str = PSER_STR;
      offs = addr - REG_PSER_BASE;
      hit = 1'b1;
    end else if (ahrm_in_span(addr, REG_SSER_BASE, REG_STRING_LEN)) begin
      sel_str = SSER_STR;
      offs = addr - REG_SSER_BASE;
      hit = 1'b1;
    end else if (ahrm_in_span(addr, REG_FW_BASE, REG_STRING_LEN)) begin
      sel_str = FW_STR;
      offs = addr - REG_FW_BASE;
      hit = 1'b1;
    end
    idx = offs[3:0];
    // Register 0 of the string is the most significant word
    word = sel_str[159 - 16 * idx -: 16];
  end

endmodule

// >>> verilog/ahrm_holding_regs.sv
// Purpose: Holding-register bank of the hydrogen analyzer behind the serial register protocol.
// Assumes: Framing, CRC and exception encoding live outside; one decoded access per request.
// Notes: Answer is registered, one cycle after the request; error marks an exception answer.
//
// Overview of operation
// - Hydrogen ppm, 32-bit read-only, registers 0/1
// - Register 132 write starts field calibration
// - Register 133: 1 aborts, 2 clears calibration
// - Register 134 reads calibration status and error
// - Register 111 holds read-only unit status
// - Registers 112/113 hold 32-bit error flags
// - Unit status bit 15 means ready
// - Hydrogen reads zero until ready
// - High-word read latches low word for next
// - Wide writes commit after both words arrive
`timescale 1ns/1ns
module ahrm_holding_regs import ahrm_pkg::*; #(
  parameter logic [159:0] MODEL_STR = {"MODEL-A", {13{8'h20}}},
  parameter logic [159:0] PSER_STR = {"PSN-0000", {12{8'h20}}},
  parameter logic [159:0] SSER_STR = {"SSN-0000", {12{8'h20}}},
  parameter logic [159:0] FW_STR = {"FW-0.0", {14{8'h20}}}
) (
  input wire logic mclk,
  input wire logic srst,
  input wire ahrm_req_t req,
  output ahrm_rsp_t rsp,
  input wire logic [31:0] h2_ppm,
  input wire logic unit_ready,
  input wire logic [14:0] unit_flags,
  input wire logic [31:0] error_word,
  input wire logic [7:0] cal_status,
  input wire logic [7:0] cal_error,
  output ahrm_cal_cmd_t cal_cmd,
  output logic [31:0] cal_gas_one_q,
  output logic [31:0] cal_date_q,
  output logic [31:0] cal_gas_two_q
);

  // Read capture latch for the low word of a wide value
  logic [15:0] latch_q;
  logic [15:0] latch_addr_q;
  logic latch_vld_q;
  // Pending high word of a wide write
  logic [15:0] pend_q;
  logic [15:0] pend_addr_q;
  logic pend_vld_q;

  logic str_hit;
  logic [15:0] str_word;

  ahrm_string_rom #(
    .MODEL_STR(MODEL_STR),
    .PSER_STR(PSER_STR),
    .SSER_STR(SSER_STR),
    .FW_STR(FW_STR)
  ) u_strings (
    .addr(req.addr),
    .hit(str_hit),
    .word(str_word)
  );

  logic [31:0] h2_view;
  logic [15:0] status_word;
  logic [15:0] pair_base;
  logic [15:0] next_addr;
  logic is_lo;

  assign h2_view = unit_ready ? h2_ppm : WIDE_RESET;
  assign status_word = {unit_ready, unit_flags};
  assign pair_base = {req.addr[15:1], 1'b0};
  assign is_lo = req.addr[0];
  assign next_addr = req.addr + 16'h0001;

  // Wide-value selection: every pair starts at an even register
  logic wide_hit;
  logic wide_wr_ok;
  logic [31:0] wide_v;

  always_comb begin
    wide_hit = 1'b1;
    wide_wr_ok = 1'b0;
    wide_v = WIDE_RESET;
    if (pair_base == REG_H2_HI) begin
      wide_v = h2_view;
    end else if (pair_base == REG_ERR_HI) begin
      wide_v = error_word;
    end else if (pair_base == REG_GAS1_HI) begin
      wide_v = cal_gas_one_q;
      wide_wr_ok = 1'b1;
    end else if (pair_base == REG_DATE_HI) begin
      wide_v = cal_date_q;
      wide_wr_ok = 1'b1;
    end else if (pair_base == REG_GAS2_HI) begin
      wide_v = cal_gas_two_q;
      wide_wr_ok = 1'b1;
    end else begin
      wide_hit = 1'b0;
    end
  end

  // Access decode
  logic rd_err;
  logic [15:0] rd_data;
  logic cap_en;
  logic wr_err;
  logic wr_hi;
  logic wr_commit;
  logic [31:0] commit_v;
  ahrm_cal_cmd_t cmd_d;

  always_comb begin
    rd_err = 1'b0;
    rd_data = WORD_RESET;
    cap_en = 1'b0;
    if (wide_hit) begin
      if (!is_lo) begin
        rd_data = wide_v[31:16];
        cap_en = 1'b1;
      end else if (latch_vld_q && latch_addr_q == req.addr) begin
        rd_data = latch_q;
      end else begin
        rd_data = wide_v[15:0];
      end
    end else if (req.addr == REG_UNIT_STATUS) begin
      rd_data = status_word;
    end else if (req.addr == REG_CAL_PROGRESS) begin
      rd_data = {cal_status, cal_error};
    end else if (str_hit) begin
      rd_data = str_word;
    end else begin
      // Unmapped or write-only registers answer with an exception
      rd_err = 1'b1;
    end
  end

  always_comb begin
    wr_err = 1'b0;
    wr_hi = 1'b0;
    wr_commit = 1'b0;
    commit_v = {pend_q, req.wdata};
    cmd_d = '0;
    cmd_d.minutes = cal_cmd.minutes;
    if (wide_hit) begin
      if (!wide_wr_ok) begin
        wr_err = 1'b1;
      end else if (!is_lo) begin
        wr_hi = 1'b1;
      end else if (pend_vld_q && pend_addr_q == req.addr) begin
        // Gas concentrations beyond the documented span are refused whole
        if (pair_base != REG_DATE_HI && commit_v > GAS_MAX_PPM) begin
          wr_err = 1'b1;
        end else begin
          wr_commit = 1'b1;
        end
      end else begin
        // Low word without its high word cannot be committed
        wr_err = 1'b1;
      end
    end else if (req.addr == REG_CAL_BEGIN) begin
      if (req.wdata >= CAL_MIN_MINUTES && req.wdata <= CAL_MAX_MINUTES) begin
        cmd_d.start = 1'b1;
        cmd_d.minutes = req.wdata;
      end else begin
        wr_err = 1'b1;
      end
    end else if (req.addr == REG_CAL_CANCEL) begin
      if (req.wdata == CMD_ABORT) begin
        cmd_d.abort = 1'b1;
      end else if (req.wdata == CMD_CLEAR) begin
        cmd_d.clear = 1'b1;
      end else begin
        wr_err = 1'b1;
      end
    end else if (req.addr == REG_GAS_SELECT) begin
      if (req.wdata == CMD_GAS_ONE) begin
        cmd_d.gas_one = 1'b1;
      end else if (req.wdata == CMD_GAS_TWO) begin
        cmd_d.gas_two = 1'b1;
      end else begin
        wr_err = 1'b1;
      end
    end else begin
      // Read-only, string and unmapped registers refuse writes
      wr_err = 1'b1;
    end
  end

  logic do_rd;
  logic do_wr;

  assign do_rd = req.valid && !req.write;
  assign do_wr = req.valid && req.write;

  // Answer register
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid;
      rsp.error <= req.valid && (req.write ? wr_err : rd_err);
      if (do_rd && !rd_err) begin
        rsp.rdata <= rd_data;
      end else if (do_wr && !wr_err) begin
        rsp.rdata <= req.wdata;
      end else begin
        rsp.rdata <= WORD_RESET;
      end
    end
  end

  // Read latch: armed by a high-word read, consumed by the next read of any kind
  always_ff @(posedge mclk) begin
    if (srst) begin
      latch_q <= WORD_RESET;
      latch_addr_q <= WORD_RESET;
      latch_vld_q <= 1'b0;
    end else if (do_rd) begin
      latch_vld_q <= cap_en;
      if (cap_en) begin
        latch_q <= wide_v[15:0];
        latch_addr_q <= next_addr;
      end
    end
  end

  // Pending high word of a wide write; any other write drops it
  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_q <= WORD_RESET;
      pend_addr_q <= WORD_RESET;
      pend_vld_q <= 1'b0;
    end else if (do_wr) begin
      pend_vld_q <= wr_hi;
      if (wr_hi) begin
        pend_q <= req.wdata;
        pend_addr_q <= next_addr;
      end
    end
  end

  // Calibration values change only on a complete pair
  always_ff @(posedge mclk) begin
    if (srst) begin
      cal_gas_one_q <= WIDE_RESET;
      cal_date_q <= WIDE_RESET;
      cal_gas_two_q <= WIDE_RESET;
    end else if (do_wr && wr_commit) begin
      if (pair_base == REG_GAS1_HI) begin
        cal_gas_one_q <= commit_v;
      end else if (pair_base == REG_DATE_HI) begin
        cal_date_q <= commit_v;
      end else begin
        cal_gas_two_q <= commit_v;
      end
    end
  end

  // Command pulses last one cycle; the duration holds until the next start
  always_ff @(posedge mclk) begin
    if (srst) begin
      cal_cmd <= '0;
    end else if (do_wr) begin
      cal_cmd <= cmd_d;
    end else begin
      cal_cmd.start <= 1'b0;
      cal_cmd.abort <= 1'b0;
      cal_cmd.clear <= 1'b0;
      cal_cmd.gas_one <= 1'b0;
      cal_cmd.gas_two <= 1'b0;
    end
  end

endmodule

// >>> verif/ahrm_master_model.sv
// Purpose: Register master issuing one decoded access at a time.
// Assumes: Requests change at the falling edge; the answer is read one cycle later.
// Notes: Released request lines show the inverse of their last value.
`timescale 1ns/1ns
module ahrm_master_model import ahrm_pkg::*; (
  input wire logic mclk,
  output ahrm_req_t req,
  input wire ahrm_rsp_t rsp
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic e);
    @(negedge mclk);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(negedge mclk);
    q = rsp.rdata;
    e = rsp.valid ? rsp.error : 1'bx;
    req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
  endtask
  task automatic rd32(input logic [15:0] a, output logic [31:0] q, output logic e);
    logic e1;
    xfer(1'b0, a, 16'h0000, q[31:16], e1);
    xfer(1'b0, a + 16'h0001, 16'h0000, q[15:0], e);
    e = e | e1;
  endtask
  task automatic wr32(input logic [15:0] a, input logic [31:0] d, output logic e);
    logic [15:0] q;
    xfer(1'b1, a, d[31:16], q, e);
    xfer(1'b1, a + 16'h0001, d[15:0], q, e);
  endtask
endmodule

// >>> verif/ahrm_holding_regs_checker.sv
// Purpose: Port checks on the holding-register bank.
// Assumes: One answer per request, one cycle later.
// Notes: Sees only a subset of the top ports.
`timescale 1ns/1ns
module ahrm_holding_regs_checker import ahrm_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  input wire ahrm_req_t req,
  input wire ahrm_rsp_t rsp,
  input wire logic [31:0] h2_ppm,
  input wire logic unit_ready,
  input wire logic [14:0] unit_flags,
  input wire logic [31:0] error_word,
  input wire logic [7:0] cal_status,
  input wire logic [7:0] cal_error,
  input wire ahrm_cal_cmd_t cal_cmd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic rd = req.valid && !req.write;
  wire logic wr = req.valid && req.write;
  wire logic [15:0] wd = req.wdata;
  wire logic [15:0] h2_hi = h2_ppm[31:16];
  wire logic [15:0] stat_w = {unit_ready, unit_flags};
  wire logic [15:0] err_hi = error_word[31:16];
  wire logic [15:0] prog_w = {cal_status, cal_error};
  wire logic cal_ok = wd >= CAL_MIN_MINUTES && wd <= CAL_MAX_MINUTES;
  answer_timing_a: assert property (req.valid |=> rsp.valid)
    else $error("no answer after request");
  stray_answer_a: assert property (rsp.valid |-> $past(req.valid))
    else $error("answer without request");
  h2_hidden_a: assert property (rd && req.addr == REG_H2_HI && !unit_ready |=> rsp.rdata == 16'h0000)
    else $error("hydrogen shown before ready");
  h2_high_a: assert property (rd && req.addr == REG_H2_HI && unit_ready |=> rsp.rdata == $past(h2_hi))
    else $error("hydrogen high word wrong");
  status_word_a: assert property (rd && req.addr == REG_UNIT_STATUS |=> rsp.rdata == $past(stat_w))
    else $error("status word wrong");
  error_high_a: assert property (rd && req.addr == REG_ERR_HI |=> rsp.rdata == $past(err_hi))
    else $error("error high word wrong");
  cal_progress_a: assert property (rd && req.addr == REG_CAL_PROGRESS |=> rsp.rdata == $past(prog_w))
    else $error("progress word wrong");
  cal_start_a: assert property (wr && req.addr == REG_CAL_BEGIN && cal_ok |=> cal_cmd.start && cal_cmd.minutes == $past(wd))
    else $error("start not issued");
  cal_refuse_a: assert property (wr && req.addr == REG_CAL_BEGIN && !cal_ok |=> rsp.error && !cal_cmd.start)
    else $error("bad duration accepted");
  cal_abort_a: assert property (wr && req.addr == REG_CAL_CANCEL && wd == CMD_ABORT |=> cal_cmd.abort && !cal_cmd.clear)
    else $error("abort not issued");
  gas_two_a: assert property (wr && req.addr == REG_GAS_SELECT && wd == CMD_GAS_TWO |=> cal_cmd.gas_two && !cal_cmd.gas_one)
    else $error("gas two not issued");
endmodule
bind ahrm_holding_regs ahrm_holding_regs_checker ahrm_holding_regs_checker_i (.mclk(mclk), .srst(srst), .req(req),
  .rsp(rsp), .h2_ppm(h2_ppm), .unit_ready(unit_ready), .unit_flags(unit_flags), .error_word(error_word),
  .cal_status(cal_status), .cal_error(cal_error), .cal_cmd(cal_cmd));

// >>> verif/ahrm_holding_regs_bench.sv
// Purpose: Self-checking bench for the holding-register bank.
// Assumes: Inputs change at the falling edge.
// Notes: Wide accesses go through the master model.
`timescale 1ns/1ns
module ahrm_holding_regs_bench import ahrm_pkg::*; ;
  logic mclk, srst, unit_ready, e;
  ahrm_req_t req;
  ahrm_rsp_t rsp;
  ahrm_cal_cmd_t cal_cmd;
  logic [31:0] h2_ppm, error_word, gas1_q, date_q, gas2_q, q32;
  logic [14:0] unit_flags;
  logic [7:0] cal_status, cal_error;
  logic [15:0] q;
  logic [15:0] mins [4] = '{16'h003B, 16'h003C, 16'h05A0, 16'h05A1};
  int mismatches, check_count, cycles;
  ahrm_holding_regs ahrm_holding_regs_i (.mclk(mclk), .srst(srst), .req(req), .rsp(rsp), .h2_ppm(h2_ppm),
    .unit_ready(unit_ready), .unit_flags(unit_flags), .error_word(error_word), .cal_status(cal_status),
    .cal_error(cal_error), .cal_cmd(cal_cmd), .cal_gas_one_q(gas1_q), .cal_date_q(date_q), .cal_gas_two_q(gas2_q));
  ahrm_master_model ahrm_master_model_i (.mclk(mclk), .req(req), .rsp(rsp));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic xe);
    ahrm_master_model_i.xfer(1'b0, a, 16'h0000, q, e);
    check($sformatf("read %0d", a), {15'h0000, xe, x}, {15'h0000, e, q});
  endtask
  // Refused writes answer zero, good ones echo the data
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic xe);
    ahrm_master_model_i.xfer(1'b1, a, d, q, e);
    check($sformatf("write %0d", a), {15'h0000, xe, xe ? 16'h0000 : d}, {15'h0000, e, q});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    srst = 1'b1;
    unit_ready = 1'b0;
    h2_ppm = 32'h0123_4567;
    unit_flags = 15'h2A5A;
    error_word = 32'hDEAD_BEEF;
    cal_status = 8'h3C;
    cal_error = 8'h5A;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    // Status bit 15 follows the ready level, so it must read clear first
    rd(REG_UNIT_STATUS, 16'h2A5A, 1'b0);
    rd(REG_H2_HI, 16'h0000, 1'b0);
    rd(REG_H2_LO, 16'h0000, 1'b0);
    unit_ready = 1'b1;
    rd(REG_H2_HI, 16'h0123, 1'b0);
    h2_ppm = 32'h89AB_CDEF;
    rd(REG_H2_LO, 16'h4567, 1'b0);
    rd(REG_H2_LO, 16'hCDEF, 1'b0);
    wr(REG_H2_LO, 16'h0001, 1'b1);
    $display("test hydrogen done");
    rd(REG_UNIT_STATUS, 16'hAA5A, 1'b0);
    wr(REG_UNIT_STATUS, 16'h0000, 1'b1);
    ahrm_master_model_i.rd32(REG_ERR_HI, q32, e);
    check("error flags", 32'hDEAD_BEEF, q32);
    rd(REG_CAL_PROGRESS, 16'h3C5A, 1'b0);
    rd(REG_MODEL_BASE, 16'h4D4F, 1'b0);
    rd(16'h0002, 16'h0000, 1'b1);
    $display("test status done");
    // Durations just outside and on both limits
    for (int i = 0; i < 4; i++) begin
      wr(REG_CAL_BEGIN, mins[i], i == 0 || i == 3);
      check("start", {31'h0, i == 1 || i == 2}, {31'h0, cal_cmd.start});
    end
    check("minutes", {16'h0000, 16'h05A0}, {16'h0000, cal_cmd.minutes});
    rd(REG_CAL_BEGIN, 16'h0000, 1'b1);
    for (int v = 1; v < 4; v++) begin
      wr(REG_CAL_CANCEL, 16'(v), v == 3);
      check("cancel", {30'h0, v == 2, v == 1}, {30'h0, cal_cmd.clear, cal_cmd.abort});
      wr(REG_GAS_SELECT, 16'(v), v == 3);
      check("gas", {30'h0, v == 2, v == 1}, {30'h0, cal_cmd.gas_two, cal_cmd.gas_one});
    end
    $display("test commands done");
    ahrm_master_model_i.wr32(REG_GAS1_HI, 32'h000F_4240, e);
    check("gas one", 32'h000F_4240, gas1_q);
    wr(16'h0081, 16'h1234, 1'b1);
    ahrm_master_model_i.wr32(REG_GAS2_HI, 32'h000F_4241, e);
    check("gas two", 32'h0000_0000, gas2_q);
    ahrm_master_model_i.wr32(REG_DATE_HI, 32'h0C1F_07E8, e);
    ahrm_master_model_i.rd32(REG_DATE_HI, q32, e);
    check("date", 32'h0C1F_07E8, q32);
    check("date reg", 32'h0C1F_07E8, date_q);
    wr(REG_GAS1_HI, 16'h0000, 1'b0);
    wr(REG_CAL_CANCEL, CMD_CLEAR, 1'b0);
    wr(16'h007F, 16'h0000, 1'b1);
    check("gas one kept", 32'h000F_4240, gas1_q);
    $display("test wide values done");
    test_done();
  end
endmodule
